// file: io_ctl_pkg.sv
// Contract
// RULE1: read third input buffer, then flag function
// RULE2: unused returned data bits drive zero
// RULE3: data-out loads selected output buffer
// RULE4: flag update follows data transfer
// RULE5: no-transfer changes flags only, no data
// RULE6: skip test reports, flags unchanged
// RULE7: peripheral completion sets completion flag
// RULE8: shared request when completion and unmasked
// RULE9: processor enable flag acts as activity flag
// RULE10: processor ignores requests while disabled
// RULE11: processor enable cleared at reset
// RULE12: masked controller never requests
// RULE13: masked request pending until unmasked
// RULE14: mask broadcast loads mask from assigned bit
// RULE15: mask cleared at reset
// RULE16: interrupt only at boundary, no channel request
// RULE17: channel requests served before interrupt
// RULE18: interrupt entry clears enable, translation off (model has no translation; entry only clears enable)
// RULE19: entry saves program counter at zero
// RULE20: entry jumps indirect through location one
// RULE21: flag field none, start, clear, pulse
// RULE22: test field activity or completion, one/zero
// RULE23: three-bit operation code decode
package io_ctl_pkg;
   localparam int word_w = 16;
   localparam int in_bits = 8;         // bits the third input buffer returns
   localparam int out_bits = 16;       // bits each output buffer keeps
   localparam int mask_bit = 3;        // accumulator bit assigned to this unit
   localparam logic [1:0] flag_none = 2'h0;
   localparam logic [1:0] flag_start = 2'h1;
   localparam logic [1:0] flag_clear = 2'h2;
   localparam logic [1:0] flag_pulse = 2'h3;
   localparam logic [1:0] test_act_one = 2'h0;
   localparam logic [1:0] test_act_zero = 2'h1;
   localparam logic [1:0] test_done_one = 2'h2;
   localparam logic [1:0] test_done_zero = 2'h3;
   localparam logic [2:0] op_flag_only = 3'h0;
   localparam logic [2:0] op_in_first = 3'h1;
   localparam logic [2:0] op_out_first = 3'h2;
   localparam logic [2:0] op_in_second = 3'h3;
   localparam logic [2:0] op_out_second = 3'h4;
   localparam logic [2:0] op_in_third = 3'h5;
   localparam logic [2:0] op_out_third = 3'h6;
   localparam logic [2:0] op_skip = 3'h7;
   localparam logic [word_w-1:0] word_reset = 16'h0000;

   typedef struct packed {
      logic valid;
      logic [2:0] op;
      logic [1:0] fn;
      logic [word_w-1:0] acc;
   } io_cmd_s;

   typedef enum logic [2:0] {
      st_idle = 3'b001,
      st_xfer = 3'b010,
      st_flag = 3'b100
   } seq_e;
endpackage

// file: flag_unit.sv
`timescale 1ns/1ps
// activity/completion/mask flags with the shared request output
module flag_unit
   import io_ctl_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic apply,
   input wire logic [1:0] fn,
   input wire logic finish,
   input wire logic mask_load,
   input wire logic mask_val,
   output logic active,
   output logic done,
   output logic masked,
   output logic pulse,
   output logic irq
);
   typedef struct packed {
      logic active;
      logic done;
      logic masked;
      logic pulse;
      logic irq;
   } flags_s;
   flags_s q_reg, q_next;

   always_comb begin
      q_next = q_reg;
      q_next.pulse = 1'b0;
      // RULE21: flag field decode
      if (apply) begin
         case (fn)
            flag_start: begin
               q_next.active = 1'b1;
               q_next.done = 1'b0;
            end
            flag_clear: begin
               q_next.active = 1'b0;
               q_next.done = 1'b0;
            end
            flag_pulse: q_next.pulse = 1'b1;
            default: ;
         endcase
      end
      // RULE7: completion sets done; set beats a clear in the same cycle
      if (finish) begin
         q_next.active = 1'b0;
         q_next.done = 1'b1;
      end
      // RULE14: mask from assigned bit
      if (mask_load)
         q_next.masked = mask_val;
      // RULE8: request while done and unmasked
      // RULE12: masked never requests; RULE13 pending done survives mask
      q_next.irq = q_next.done & ~q_next.masked;
   end

   // RULE15: mask cleared on reset
   always_ff @(posedge clock) begin
      if (!rst_n)
         q_reg <= '0;
      else
         q_reg <= q_next;
   end

   assign active = q_reg.active;
   assign done = q_reg.done;
   assign masked = q_reg.masked;
   assign pulse = q_reg.pulse;
   assign irq = q_reg.irq;

   // a_irq_follows: RULE8
   a_irq_follows: assert property (@(posedge clock) disable iff (!rst_n)
      irq == (done & ~masked))
      else $error("request not matching flags");
   // a_mask_blocks: RULE12
   a_mask_blocks: assert property (@(posedge clock) disable iff (!rst_n)
      masked |-> !irq)
      else $error("masked unit requests");
   // a_unmask_pends: RULE13
   a_unmask_pends: assert property (@(posedge clock) disable iff (!rst_n)
      (masked && done && mask_load && !mask_val && !apply) |=> irq)
      else $error("pending request lost");
   // a_finish_sets: RULE7
   a_finish_sets: assert property (@(posedge clock) disable iff (!rst_n)
      finish |=> done)
      else $error("completion not set");
endmodule

// file: io_controller.sv
`timescale 1ns/1ps
module io_controller
   import io_ctl_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire io_cmd_s cmd,
   input wire logic mask_broadcast,
   input wire logic [word_w-1:0] mask_word,
   input wire logic peripheral_finish,
   input wire logic [in_bits-1:0] third_in_data,
   output logic [word_w-1:0] read_data,
   output logic read_valid,
   output logic skip,
   output logic skip_valid,
   output logic [out_bits-1:0] first_out_buf,
   output logic [out_bits-1:0] second_out_buf,
   output logic [out_bits-1:0] third_out_buf,
   output logic activity,
   output logic completion,
   output logic int_mask,
   output logic special_pulse,
   output logic int_request
);
   typedef struct packed {
      seq_e st;
      logic [1:0] fn;
      logic [word_w-1:0] rd;
      logic rv;
      logic sk;
      logic sv;
      logic [out_bits-1:0] ob1;
      logic [out_bits-1:0] ob2;
      logic [out_bits-1:0] ob3;
      logic fin;
   } ctl_s;
   ctl_s s_reg, s_next;
   logic act_w, done_w, apply_w;

   ////////////////////////////////////////////////////////////////////
   // test field evaluation
   function automatic logic test_hit(input logic [1:0] t,
                                     input logic a, input logic d);
      case (t)
         test_act_one: test_hit = a;
         test_act_zero: test_hit = ~a;
         test_done_one: test_hit = d;
         default: test_hit = ~d;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////
   // instruction sequencer: transfer in one cycle, flags two cycles later; no-transfer flags one cycle later
   always_comb begin
      s_next = s_reg;
      s_next.rv = 1'b0;
      s_next.sv = 1'b0;
      s_next.fin = peripheral_finish; // finish registered once, same domain
      apply_w = 1'b0;
      case (s_reg.st)
         st_idle: begin
            if (cmd.valid) begin
               s_next.fn = cmd.fn;
               // RULE23: opcode decode
               case (cmd.op)
                  op_in_third: begin
                     // RULE1: return third buffer
                     // RULE2: unused bits zero
                     s_next.rd = {{(word_w-in_bits){1'b0}}, third_in_data};
                     s_next.rv = 1'b1;
                     s_next.st = st_xfer;
                  end
                  op_in_first, op_in_second: begin
                     // buffers not built here read as zero
                     s_next.rd = word_reset;
                     s_next.rv = 1'b1;
                     s_next.st = st_xfer;
                  end
                  // RULE3: load output buffers
                  op_out_first: begin
                     s_next.ob1 = cmd.acc[out_bits-1:0];
                     s_next.st = st_xfer;
                  end
                  op_out_second: begin
                     s_next.ob2 = cmd.acc[out_bits-1:0];
                     s_next.st = st_xfer;
                  end
                  op_out_third: begin
                     s_next.ob3 = cmd.acc[out_bits-1:0];
                     s_next.st = st_xfer;
                  end
                  op_skip: begin
                     // RULE6: report test, flags left alone
                     // RULE22: test field decode
                     s_next.sk = test_hit(cmd.fn, act_w, done_w);
                     s_next.sv = 1'b1;
                  end
                  // RULE5: no-transfer only touches flags
                  default: s_next.st = st_flag;
               endcase
            end
         end
         st_xfer: s_next.st = st_flag;
         st_flag: begin
            // RULE4: flags after transfer completes
            apply_w = 1'b1;
            s_next.st = st_idle;
         end
         default: s_next.st = st_idle;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s_reg <= '0;
         s_reg.st <= st_idle;
      end else
         s_reg <= s_next;
   end

   ////////////////////////////////////////////////////////////////////
   // flags; pulse and request come from flops inside the unit
   flag_unit u_flags (
      .clock(clock),
      .rst_n(rst_n),
      .apply(apply_w),
      .fn(s_reg.fn),
      .finish(s_reg.fin),
      .mask_load(mask_broadcast),
      .mask_val(mask_word[mask_bit]),
      .active(act_w),
      .done(done_w),
      .masked(int_mask),
      .pulse(special_pulse),
      .irq(int_request)
   );

   assign activity = act_w;
   assign completion = done_w;
   assign read_data = s_reg.rd;
   assign read_valid = s_reg.rv;
   assign skip = s_reg.sk;
   assign skip_valid = s_reg.sv;
   assign first_out_buf = s_reg.ob1;
   assign second_out_buf = s_reg.ob2;
   assign third_out_buf = s_reg.ob3;

   // a_skip_keeps: RULE6
   a_skip_keeps: assert property (@(posedge clock) disable iff (!rst_n)
      (s_reg.st == st_idle && cmd.valid && cmd.op == op_skip
       && !s_reg.fin) |=> $stable(activity) && $stable(completion))
      else $error("skip changed flags");
   // a_read_zero: RULE2
   a_read_zero: assert property (@(posedge clock) disable iff (!rst_n)
      read_valid |-> read_data[word_w-1:in_bits] == '0)
      else $error("unused bits not zero");
   // a_start_late: RULE4
   a_start_late: assert property (@(posedge clock) disable iff (!rst_n)
      (s_reg.st == st_idle && cmd.valid && cmd.op == op_out_first
       && cmd.fn == flag_start) |=> ##2 activity)
      else $error("start not applied after transfer");
   // a_load_buf: RULE3
   a_load_buf: assert property (@(posedge clock) disable iff (!rst_n)
      (s_reg.st == st_idle && cmd.valid && cmd.op == op_out_third)
      |=> third_out_buf == $past(cmd.acc))
      else $error("third buffer not loaded");
endmodule

// file: cpu_model.sv
`timescale 1ns/1ps
// processor side: issues bus instructions and honours the request line
module cpu_model
   import io_ctl_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic int_request,
   output io_cmd_s cmd,
   output logic mask_broadcast,
   output logic [word_w-1:0] mask_word,
   output logic interrupt_enable_flag,
   output logic int_taken
);
   // handler address held in location one; value is the bench's choice
   localparam logic [word_w-1:0] handler_addr = 16'h0200;
   localparam logic [word_w-1:0] pc_start = 16'h0100;
   logic ion_set = 1'b0;
   logic chan_req = 1'b0; // data channel request, driven by the bench
   logic [word_w-1:0] pc_reg;
   logic [word_w-1:0] loc0_reg;
   initial begin
      cmd = '0;
      mask_broadcast = 1'b0;
      mask_word = 16'h0000;
   end
   // one instruction; the caller owns the idle gap after it
   task automatic issue(input logic [2:0] op, input logic [1:0] fn,
                        input logic [word_w-1:0] acc);
      @(posedge clock);
      cmd <= '{valid: 1'b1, op: op, fn: fn, acc: acc};
      @(posedge clock);
      cmd.valid <= 1'b0;
   endtask
   task automatic mask(input logic [word_w-1:0] w);
      @(posedge clock);
      mask_word <= w;
      mask_broadcast <= 1'b1;
      @(posedge clock);
      mask_broadcast <= 1'b0;
   endtask
   // start command to the processor's own code
   task automatic enable();
      @(posedge clock);
      ion_set <= 1'b1;
      @(posedge clock);
      ion_set <= 1'b0;
   endtask
   always_ff @(posedge clock) begin
      int_taken <= 1'b0;
      if (!rst_n) begin
         interrupt_enable_flag <= 1'b0;
         pc_reg <= pc_start;
         loc0_reg <= 16'h0000;
      end else if (interrupt_enable_flag && int_request && !chan_req) begin
         interrupt_enable_flag <= 1'b0;
         int_taken <= 1'b1;
         // save counter at zero, jump via one
         loc0_reg <= pc_reg;
         pc_reg <= handler_addr;
      end else if (ion_set) begin
         interrupt_enable_flag <= 1'b1;
      end
   end
endmodule

// file: io_flag_interrupt_control_test.sv
`timescale 1ns/1ps
module io_flag_interrupt_control_test
   import io_ctl_pkg::*;
;
   typedef struct packed {
      logic [2:0] op;
      logic [1:0] fn;
      logic [15:0] acc;
      logic act;
      logic done;
   } row_s;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic peripheral_finish = 1'b0;
   logic [in_bits-1:0] third_in_data = 8'ha5;
   io_cmd_s cmd;
   logic mask_broadcast, interrupt_enable_flag, int_taken, read_valid, skip, skip_valid;
   logic activity, completion, int_mask, special_pulse, int_request;
   logic [word_w-1:0] mask_word, read_data;
   logic [word_w-1:0] b [3];
   logic [word_w-1:0] eb [3] = '{16'h0000, 16'h0000, 16'h0000};
   logic prev_act = 1'b0;
   int err_total = 0;
   int comparisons = 0;
   int n;
   logic [word_w-1:0] exp_rd;
   row_s rows [6] = '{
      '{op_out_first, flag_start, 16'h1111, 1'b1, 1'b0},
      '{op_out_second, flag_none, 16'h2222, 1'b1, 1'b0},
      '{op_out_third, flag_clear, 16'h3333, 1'b0, 1'b0},
      '{op_in_third, flag_start, 16'hffff, 1'b1, 1'b0},
      '{op_flag_only, flag_clear, 16'h0000, 1'b0, 1'b0},
      '{op_in_first, flag_pulse, 16'h0000, 1'b0, 1'b0}};

   always #5 clock = ~clock;

   io_controller uut (.clock(clock), .rst_n(rst_n), .cmd(cmd),
      .mask_broadcast(mask_broadcast), .mask_word(mask_word),
      .peripheral_finish(peripheral_finish), .third_in_data(third_in_data),
      .read_data(read_data), .read_valid(read_valid), .skip(skip),
      .skip_valid(skip_valid), .first_out_buf(b[0]), .second_out_buf(b[1]),
      .third_out_buf(b[2]), .activity(activity), .completion(completion),
      .int_mask(int_mask), .special_pulse(special_pulse),
      .int_request(int_request));
   cpu_model cpu (.clock(clock), .rst_n(rst_n), .int_request(int_request),
      .cmd(cmd), .mask_broadcast(mask_broadcast), .mask_word(mask_word),
      .interrupt_enable_flag(interrupt_enable_flag), .int_taken(int_taken));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("mismatches %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic settle(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      // reset held over five edges, released on an edge
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      settle(1);
      check({interrupt_enable_flag, int_mask, activity, completion}, 16'h0);
      foreach (rows[i]) begin
         cpu.issue(rows[i].op, rows[i].fn, rows[i].acc);
         if (rows[i].op[0] == 1'b0 && rows[i].op != op_flag_only)
            eb[rows[i].op[2:1] - 2'h1] = rows[i].acc;
         exp_rd = (rows[i].op == op_in_third) ? 16'h00a5 : 16'h0000;
         // read_valid stands only in the cycle after the take edge
         #1;
         check(read_valid, rows[i].op[0]);
         if (rows[i].op[0])
            check(read_data, exp_rd);
         foreach (b[j]) check(b[j], eb[j]);
         check(activity, prev_act);
         settle(2);
         check(activity, rows[i].act);
         check(completion, rows[i].done);
         check(special_pulse, rows[i].fn == flag_pulse);
         prev_act = rows[i].act;
      end
      // finish with activity low leaves only completion set
      @(posedge clock);
      peripheral_finish <= 1'b1;
      @(posedge clock);
      peripheral_finish <= 1'b0;
      settle(3);
      check({completion, int_request}, 2'b11);
      for (int t = 0; t < 4; t++) begin
         cpu.issue(op_skip, t[1:0], 16'h0);
         // skip_valid is a one-cycle pulse
         #1;
         check({skip_valid, skip}, {1'b1, t == 1 || t == 2});
         check({activity, completion}, 2'b01);
      end
      // other units' bits must not reach this mask
      cpu.mask(16'hfff7);
      settle(2);
      check({int_mask, int_request}, 2'b01);
      cpu.mask(16'h0008);
      cpu.enable();
      settle(4);
      check({int_mask, int_request, int_taken}, 3'b100);
      // a waiting channel request holds off interrupt entry
      @(posedge clock);
      cpu.chan_req <= 1'b1;
      cpu.mask(16'h0000);
      settle(3);
      check({int_request, interrupt_enable_flag}, 2'b11);
      @(posedge clock);
      cpu.chan_req <= 1'b0;
      for (n = 0; n < 8 && int_taken !== 1'b1; n++) settle(1);
      check(int_taken, 1'b1);
      check(cpu.loc0_reg, 16'h0100);
      check(cpu.pc_reg, 16'h0200);
      cpu.mask(16'h0008);
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      settle(1);
      check({int_mask, completion, int_request, interrupt_enable_flag}, 4'h0);
      end_sim();
   end
endmodule
